// *** design/hftc_control.sv ***
// register bank and control for receive and transmit configuration
// assumes fifo controllers on the same clock give one-cycle pop strobes
//
// Overview of operation
// RULE1 - 12-bit countdown raises interrupt at zero
// RULE2 - each host dword read decrements countdown
// RULE3 - new countdown write replaces remaining count
// RULE4 - rx flush clears both receive pointers
// RULE5 - five-bit byte offset before packet data
// RULE6 - host keeps offset low bits while running
// RULE7 - upper offset bits apply next dword
// RULE8 - end alignment decodes 4, 16, 32
// RULE9 - pad dwords up to end alignment
// RULE10 - host changes alignment only between packets
// RULE11 - tx status flush clears status pointers
// RULE12 - tx data flush clears data pointers
// RULE13 - full status fifo suspends unless permitted
// RULE14 - permit bit leaves full interrupt alone
// RULE15 - transmitter on sends queued data
// RULE16 - tx on clears after halt completes
// RULE17 - halt finishes frame then self-clears
// RULE18 - halt writes ignored while halt reads one
// RULE19 - reserved reads zero, flushes read zero
module hftc_control
    import hftc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire hftc_bus_req_type bus_req,
    output logic [31:0] bus_rdata,
    // receive data path
    input wire logic rx_dword_pop,
    input wire logic rx_buffer_last,
    output logic rx_transfer_int,
    output logic [4:0] rx_payload_shift,
    output logic [2:0] rx_dword_shift,
    output logic [3:0] rx_pad_dwords,
    // transmit path
    input wire logic tx_frame_active,
    input wire logic tx_status_full,
    output logic tx_run,
    output logic tx_status_full_int,
    // flush pulses
    output hftc_flush_type flush
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [11:0] rx_transfer_countdown, next_rx_transfer_countdown;
    logic countdown_armed, next_countdown_armed;
    logic [4:0] next_rx_payload_shift;
    logic [2:0] next_rx_dword_shift;
    logic [1:0] rx_end_align, next_rx_end_align;
    logic tx_status_overrun_permit, next_tx_status_overrun_permit;
    logic tx_on, next_tx_on;
    logic tx_halt, next_tx_halt;
    logic next_rx_transfer_int;
    logic [3:0] pad_count, next_pad_count;
    logic [3:0] next_rx_pad_dwords;
    hftc_flush_type next_flush;
    logic [31:0] next_bus_rdata;
    logic wr_rx, wr_tx;

    // dwords per alignment block, minus one, used as a mask
    function automatic logic [2:0] align_mask(input logic [1:0] code);
        unique case (code)
            align_4: align_mask = 3'h0;
            align_16: align_mask = 3'h3;
            align_32: align_mask = 3'h7;
            default: align_mask = 3'h0; // reserved treated as 4-byte
        endcase
    endfunction

    assign wr_rx = bus_req.write && bus_req.addr == receive_config_offset;
    assign wr_tx = bus_req.write && bus_req.addr == transmit_config_offset;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_rx_transfer_countdown = rx_transfer_countdown;
        next_countdown_armed = countdown_armed;
        next_rx_transfer_int = 1'b0;
        next_rx_payload_shift = rx_payload_shift;
        next_rx_dword_shift = rx_dword_shift;
        next_rx_end_align = rx_end_align;
        next_tx_status_overrun_permit = tx_status_overrun_permit;
        next_tx_on = tx_on;
        next_tx_halt = tx_halt;
        next_flush = '0;
        next_pad_count = pad_count;

        // a pop that hits zero fires once, then the count idles
        if (countdown_armed && rx_dword_pop) begin
            next_rx_transfer_countdown = rx_transfer_countdown - 12'h001; // RULE2
            if (rx_transfer_countdown == 12'h001) begin
                next_rx_transfer_int = 1'b1; // RULE1
                next_countdown_armed = 1'b0;
            end
        end
        // pads counted per dword in the buffer; reset when buffer ends
        if (rx_dword_pop) begin
            next_pad_count = rx_buffer_last ? 4'h0 : pad_count + 4'h1; // RULE9
            // dword offset only moves on a dword boundary
            next_rx_dword_shift = rx_payload_shift[4:2]; // RULE7
        end

        if (wr_rx) begin
            next_rx_transfer_countdown =
                bus_req.wdata[rx_countdown_lsb +: 12]; // RULE3
            next_countdown_armed = |bus_req.wdata[rx_countdown_lsb +: 12];
            next_rx_payload_shift = bus_req.wdata[rx_shift_lsb +: 5]; // RULE5
            next_rx_end_align = bus_req.wdata[rx_end_align_lsb +: 2]; // RULE8
            next_flush.rx_flush = bus_req.wdata[rx_flush_bit]; // RULE4
        end

        if (wr_tx) begin
            next_tx_status_overrun_permit =
                bus_req.wdata[tx_overrun_permit_bit];
            next_tx_on = bus_req.wdata[tx_on_bit];
            // halt writes only land while halt reads zero
            if (!tx_halt) begin
                next_tx_halt = bus_req.wdata[tx_halt_bit]; // RULE18
            end
            next_flush.tx_status_flush =
                bus_req.wdata[tx_status_flush_bit]; // RULE11
            next_flush.tx_data_flush =
                bus_req.wdata[tx_data_flush_bit]; // RULE12
        end

        // halt completes only once the frame in flight is done
        if (tx_halt && !tx_frame_active) begin
            next_tx_halt = 1'b0; // RULE17
            next_tx_on = 1'b0; // RULE16
        end

        // owed pads taken from next state so the flop matches the new count
        next_rx_pad_dwords[3] = 1'b0;
        next_rx_pad_dwords[2:0] = align_mask(next_rx_end_align)
            & (3'h0 - next_pad_count[2:0]); // RULE9
    end

    // read data; flush bits and reserved bits always read zero
    always_comb begin
        next_bus_rdata = 32'h0000_0000; // RULE19
        if (bus_req.read && bus_req.addr == receive_config_offset) begin
            next_bus_rdata[rx_end_align_lsb +: 2] = rx_end_align;
            next_bus_rdata[rx_countdown_lsb +: 12] = rx_transfer_countdown;
            next_bus_rdata[rx_shift_lsb +: 5] = rx_payload_shift;
        end else if (bus_req.read
                     && bus_req.addr == transmit_config_offset) begin
            next_bus_rdata[tx_overrun_permit_bit] = tx_status_overrun_permit;
            next_bus_rdata[tx_on_bit] = tx_on;
            next_bus_rdata[tx_halt_bit] = tx_halt;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_transfer_countdown <= rx_countdown_reset;
            countdown_armed <= 1'b0;
            rx_transfer_int <= 1'b0;
            rx_payload_shift <= rx_shift_reset;
            rx_dword_shift <= 3'h0;
            rx_end_align <= rx_end_align_reset;
            tx_status_overrun_permit <= 1'b0;
            tx_on <= 1'b0;
            tx_halt <= 1'b0;
            pad_count <= 4'h0;
            rx_pad_dwords <= 4'h0;
            flush <= '0;
            bus_rdata <= 32'h0000_0000;
        end else begin
            rx_transfer_countdown <= next_rx_transfer_countdown;
            countdown_armed <= next_countdown_armed;
            rx_transfer_int <= next_rx_transfer_int;
            rx_payload_shift <= next_rx_payload_shift;
            rx_dword_shift <= next_rx_dword_shift;
            rx_end_align <= next_rx_end_align;
            tx_status_overrun_permit <= next_tx_status_overrun_permit;
            tx_on <= next_tx_on;
            tx_halt <= next_tx_halt;
            pad_count <= next_pad_count;
            rx_pad_dwords <= next_rx_pad_dwords;
            flush <= next_flush;
            bus_rdata <= next_bus_rdata;
        end
    end

    // no new frame starts once a halt is pending; the frame in flight
    // finishes on its own, so the halt only gates the next start
    // suspend on full status fifo unless overrun is permitted
    assign tx_run = tx_on && !tx_halt // RULE15 RULE17
        && (tx_status_overrun_permit || !tx_status_full); // RULE13
    // full interrupt source ignores the permit bit
    assign tx_status_full_int = tx_status_full; // RULE14

    // ------------------------------------------------------------------
    // receive checks
    // ------------------------------------------------------------------
    a_count_decrement: assert property ( // RULE2
        @(posedge clock) disable iff (!rst_n)
        countdown_armed && rx_dword_pop && !wr_rx |=>
        rx_transfer_countdown == $past(rx_transfer_countdown) - 12'h001)
        else $error("countdown did not decrement");
    a_count_hold: assert property ( // RULE2
        @(posedge clock) disable iff (!rst_n)
        !rx_dword_pop && !wr_rx |=> $stable(rx_transfer_countdown))
        else $error("countdown moved without a pop");
    a_count_int: assert property ( // RULE1
        @(posedge clock) disable iff (!rst_n)
        countdown_armed && rx_dword_pop && !wr_rx
        && rx_transfer_countdown == 12'h001 |=> rx_transfer_int)
        else $error("transfer interrupt missing");
    a_int_cause: assert property ( // RULE1
        @(posedge clock) disable iff (!rst_n)
        !(countdown_armed && rx_dword_pop
        && rx_transfer_countdown == 12'h001) |=> !rx_transfer_int)
        else $error("transfer interrupt without final pop");
    a_armed_nonzero: assert property ( // RULE1
        @(posedge clock) disable iff (!rst_n)
        countdown_armed |-> rx_transfer_countdown != 12'h000)
        else $error("countdown armed at zero");
    a_count_reload: assert property ( // RULE3
        @(posedge clock) disable iff (!rst_n)
        wr_rx |=> rx_transfer_countdown
        == $past(bus_req.wdata[rx_countdown_lsb +: 12]))
        else $error("countdown not reloaded");
    a_rx_flush_pulse: assert property ( // RULE4
        @(posedge clock) disable iff (!rst_n)
        wr_rx && bus_req.wdata[rx_flush_bit] |=> flush.rx_flush ##1
        !flush.rx_flush || $past(wr_rx))
        else $error("rx flush pulse wrong");
    a_rx_flush_idle: assert property ( // RULE4
        @(posedge clock) disable iff (!rst_n)
        !wr_rx |=> !flush.rx_flush)
        else $error("rx flush without a write");
    a_shift_load: assert property ( // RULE5
        @(posedge clock) disable iff (!rst_n)
        wr_rx |=> rx_payload_shift
        == $past(bus_req.wdata[rx_shift_lsb +: 5]))
        else $error("byte offset not loaded");
    a_dword_shift: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        rx_dword_pop |=> rx_dword_shift == $past(rx_payload_shift[4:2]))
        else $error("dword offset not applied");
    a_dword_hold: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        !rx_dword_pop |=> $stable(rx_dword_shift))
        else $error("dword offset moved between reads");
    a_align_load: assert property ( // RULE8
        @(posedge clock) disable iff (!rst_n)
        wr_rx |=> rx_end_align
        == $past(bus_req.wdata[rx_end_align_lsb +: 2]))
        else $error("end alignment not loaded");
    a_pad_bound: assert property ( // RULE9
        @(posedge clock) disable iff (!rst_n)
        rx_pad_dwords[2:0] <= align_mask(rx_end_align)
        && !rx_pad_dwords[3])
        else $error("pad count beyond alignment");

    // ------------------------------------------------------------------
    // transmit checks
    // ------------------------------------------------------------------
    a_txs_flush: assert property ( // RULE11
        @(posedge clock) disable iff (!rst_n)
        wr_tx && bus_req.wdata[tx_status_flush_bit]
        |=> flush.tx_status_flush)
        else $error("tx status flush missing");
    a_txd_flush: assert property ( // RULE12
        @(posedge clock) disable iff (!rst_n)
        wr_tx && bus_req.wdata[tx_data_flush_bit] |=> flush.tx_data_flush)
        else $error("tx data flush missing");
    a_tx_flush_idle: assert property ( // RULE11 RULE12
        @(posedge clock) disable iff (!rst_n)
        !wr_tx |=> !flush.tx_status_flush && !flush.tx_data_flush)
        else $error("tx flush without a write");
    a_suspend_full: assert property ( // RULE13
        @(posedge clock) disable iff (!rst_n)
        tx_status_full && !tx_status_overrun_permit |-> !tx_run)
        else $error("tx ran with full status fifo");
    a_permit_run: assert property ( // RULE13
        @(posedge clock) disable iff (!rst_n)
        tx_on && !tx_halt && tx_status_overrun_permit |-> tx_run)
        else $error("tx held although overrun permitted");
    a_run_needs_on: assert property ( // RULE15
        @(posedge clock) disable iff (!rst_n)
        !tx_on |-> !tx_run)
        else $error("tx ran while disabled");
    a_halt_no_start: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        tx_halt |-> !tx_run)
        else $error("tx allowed to start while halting");
    a_halt_by_write: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        !tx_halt && !(wr_tx && bus_req.wdata[tx_halt_bit]) |=> !tx_halt)
        else $error("halt set without a write");
    a_halt_clears: assert property ( // RULE16
        @(posedge clock) disable iff (!rst_n)
        tx_halt && !tx_frame_active |=> !tx_halt && !tx_on)
        else $error("halt did not complete");
    a_halt_holds: assert property ( // RULE18
        @(posedge clock) disable iff (!rst_n)
        tx_halt && tx_frame_active |=> tx_halt)
        else $error("halt dropped mid frame");
    a_rdata_idle: assert property ( // RULE19
        @(posedge clock) disable iff (!rst_n)
        !bus_req.read |=> bus_rdata == 32'h0000_0000)
        else $error("read data without a read");
    a_tx_rdata_resv: assert property ( // RULE19
        @(posedge clock) disable iff (!rst_n)
        bus_req.read && bus_req.addr == transmit_config_offset
        |=> bus_rdata[31:3] == 29'h0)
        else $error("tx reserved bits read nonzero");

endmodule // hftc_control

// *** design/hftc_pkg.sv ***
// package for the host fifo tx/rx control register bank
// assumes a synchronous register port with 32-bit words at byte offsets
package hftc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] receive_config_offset = 8'h6c;
    localparam logic [7:0] transmit_config_offset = 8'h70;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int rx_end_align_lsb = 30;
    localparam int rx_countdown_lsb = 16;
    localparam int rx_flush_bit = 15;
    localparam int rx_shift_lsb = 8;
    localparam int tx_status_flush_bit = 15;
    localparam int tx_data_flush_bit = 14;
    localparam int tx_overrun_permit_bit = 2;
    localparam int tx_on_bit = 1;
    localparam int tx_halt_bit = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] rx_countdown_reset = 12'h000;
    localparam logic [4:0] rx_shift_reset = 5'h00;
    localparam logic [1:0] rx_end_align_reset = 2'h0;

    // end alignment codes
    typedef enum logic [1:0] {
        align_4 = 2'b00,
        align_16 = 2'b01,
        align_32 = 2'b10,
        align_reserved = 2'b11
    } hftc_align_type;

    // register bus request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hftc_bus_req_type;

    // pulses to the fifo controllers and transmitter
    typedef struct packed {
        logic rx_flush;
        logic tx_status_flush;
        logic tx_data_flush;
    } hftc_flush_type;

endpackage : hftc_pkg

// *** tb/hftc_tx_model.sv ***
// transmitter stand-in that sends one frame when told to
// assumes the control block's clock and reset; frames only start if allowed
module hftc_tx_model #(
    parameter int frame_len = 20
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control side
    input wire logic tx_run,
    input wire logic start,
    output logic tx_frame_active
);
    timeunit 1ns;
    timeprecision 1ps;
    int left;
    // a frame in flight runs to its end even if tx_run drops meanwhile
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            left <= 0;
        end else if (start && tx_run && left == 0) begin
            left <= frame_len;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign tx_frame_active = (left != 0);
endmodule // hftc_tx_model

// *** tb/tb_hftc_control.sv ***
// self-checking bench for the rx/tx configuration control block
// assumes the host side is driven here at falling edges
module tb_hftc_control;
    import hftc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0;
    logic rst_n = 0;
    hftc_bus_req_type bus_req = '0;
    logic pop = 0, last = 0, full = 0, start = 0, rd_d = 0;
    logic [31:0] bus_rdata, seed = 32'h30, v;
    logic rx_int, tx_run, full_int, act;
    logic [4:0] s, pshift;
    logic [2:0] dshift;
    logic [3:0] pad;
    logic [11:0] c;
    hftc_flush_type flush;
    logic [31:0] expq[$];
    int pe[4] = '{0, 1, 5, 0};
    int n_fail = 0, samples_checked = 0, i;
    always #5 clock = ~clock;
    hftc_control dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .rx_dword_pop(pop), .rx_buffer_last(last),
        .rx_transfer_int(rx_int), .rx_payload_shift(pshift),
        .rx_dword_shift(dshift), .rx_pad_dwords(pad),
        .tx_frame_active(act), .tx_status_full(full), .tx_run(tx_run),
        .tx_status_full_int(full_int), .flush(flush));
    hftc_tx_model #(.frame_len(20)) txm (.clock(clock), .rst_n(rst_n),
        .tx_run(tx_run), .start(start), .tx_frame_active(act));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(negedge clock) begin
            bus_req.write = 1;
            bus_req.addr = a;
            bus_req.wdata = d;
        end
        @(negedge clock) bus_req.write = 0;
    endtask
    // read data is compared by the monitor one cycle later
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(negedge clock) begin
            bus_req.read = 1;
            bus_req.addr = a;
            expq.push_back(e);
        end
        @(negedge clock) bus_req.read = 0;
    endtask
    task automatic pops(int n, logic l);
        @(negedge clock) begin
            pop = 1;
            last = l;
        end
        repeat (n) @(negedge clock);
        pop = 0;
        last = 0;
    endtask
    always @(posedge clock) rd_d <= bus_req.read;
    always @(negedge clock) begin
        if (rd_d && expq.size() > 0) begin
            chk("bus_rdata", expq.pop_front(), bus_rdata);
        end
    end
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock) rst_n = 1;
        rd(8'h6c, 32'h0);
        rd(8'h70, 32'h0);
        rd(8'h74, 32'h0);
        v = xs();
        s = v[4:0] | 5'h04;
        // low offset bits set only while the receiver is idle
        wr(8'h6c, {19'h0, s, 8'hff});
        chk("payload_shift", {27'h0, s}, {27'h0, pshift});
        chk("dword_shift_old", 32'h0, {29'h0, dshift});
        pops(1, 0);
        chk("dword_shift", {29'h0, s[4:2]}, {29'h0, dshift});
        rd(8'h6c, {19'h0, s, 8'h0});
        c = {9'h0, v[10:8]} + 12'h4;
        wr(8'h6c, {4'h0, c, 1'b1, 2'b0, s, 8'h0});
        chk("flush", 32'h4, {29'h0, flush});
        rd(8'h6c, {4'h0, c, 3'b0, s, 8'h0});
        pops(2, 0);
        rd(8'h6c, {4'h0, c - 12'h2, 3'b0, s, 8'h0});
        wr(8'h6c, {4'h0, 12'h3, 3'b0, s, 8'h0});
        pops(2, 0);
        chk("rx_int_early", 32'h0, {31'h0, rx_int});
        pops(1, 0);
        chk("rx_int", 32'h1, {31'h0, rx_int});
        @(negedge clock) chk("rx_int_end", 32'h0, {31'h0, rx_int});
        for (i = 0; i < 4; i++) begin
            // alignment changed just before the dword that ends a buffer
            wr(8'h6c, {i[1:0], 17'h0, s, 8'h0});
            pops(1, 1);
            pops(3, 0);
            chk("pad", pe[i], {28'h0, pad});
        end
        wr(8'h70, 32'h2);
        chk("tx_run_on", 32'h1, {31'h0, tx_run});
        @(negedge clock) full = 1;
        #1 chk("tx_run_full", 32'h0, {31'h0, tx_run});
        chk("full_int", 32'h1, {31'h0, full_int});
        wr(8'h70, 32'h6);
        chk("tx_run_permit", 32'h1, {31'h0, tx_run});
        chk("full_int_permit", 32'h1, {31'h0, full_int});
        @(negedge clock) full = 0;
        wr(8'h70, 32'hffffc006);
        chk("tx_flush", 32'h3, {29'h0, flush});
        rd(8'h70, 32'h6);
        @(negedge clock) start = 1;
        @(negedge clock) start = 0;
        wr(8'h70, 32'h3);
        chk("tx_run_halt", 32'h0, {31'h0, tx_run});
        rd(8'h70, 32'h3);
        wr(8'h70, 32'h2);
        rd(8'h70, 32'h3);
        for (i = 0; i < 50 && act; i++) @(negedge clock);
        if (act) begin
            n_fail++;
            close_out();
        end
        @(negedge clock);
        rd(8'h70, 32'h0);
        repeat (2) @(negedge clock);
        close_out();
    end
endmodule // tb_hftc_control
